// [hw/sprite_engine.sv]
// sprite engine: line fetch from video ram, dot rendering, status over apb
`timescale 1ns/1ps
// Overview of operation
// - sprite mode follows the screen mode register, no own control bit
// - 32 sprites; lower number wins, hidden pixels of lower precedence
// - mode 1 shows at most four highest-precedence sprites per line
// - mode 2 shows at most eight per line, merge lines included
// - mode 1 colour-1 overlap of two sprites sets status bit 5
// - mode 1 fifth sprite on a line sets bit 6, number in low bits
// - mode 2 ninth sprite on a line sets bit 6, number in low bits
// - control 1 bit 1 picks 16x16 or 8x8; bit 0 doubles size
// - mode 1 y of 208 hides that sprite and all later ones
// - mode 2 y of 216 hides that sprite and all later ones
// - four attribute bytes per sprite: y, x, pattern, colour in mode 1
// - pattern base from register 6, eight bytes each, 16x16 uses four
// - early-shift bit draws the sprite 32 dots further left
// - mode 1 pattern-1 dots use attribute colour, pattern-0 transparent
// - mode 2 colour, shift, merge, ignore come per line from colour table
// - colour table base is attribute base minus 512
// - merge lines show only over lower sprites, colours ORed
// - merge lines never report a collision
// - unmerged, unignored nonzero overlap sets bit 5; reading status 0 clears it
// - collision loads coordinates unless pointer or pen flag set
// - reading status 5 clears coordinate registers 3 to 6
// - stored x is position plus 12, stored y position plus 8
module sprite_engine
  import sprite_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // video ram read port
  output logic VRAM_REQ,
  output logic [16:0] VRAM_ADDR,
  input wire logic VRAM_ACK,
  input wire logic [7:0] VRAM_DATA,
  // raster timing
  input wire logic LINE_START,
  input wire logic [7:0] LINE_Y,
  input wire logic PIX_EN,
  input wire logic [7:0] PIX_X,
  // sprite dot out
  output logic SPR_VALID,
  output logic [3:0] SPR_COLOR
);

  // ======================================================================
  // declarations
  logic [1:0] ctrl1_ff;
  logic [5:0] patbase_ff;
  logic [7:0] ctrl8_ff;
  logic [9:0] attrbase_ff;
  screen_mode_e scrmode_ff;
  logic coll_ff, ovf_ff;
  logic [4:0] ovfnum_ff;
  logic [9:0] collx_ff, colly_ff;
  logic [31:0] rdata;
  logic mapped;
  logic apb_done, rd_stat0, rd_stat5;
  fetch_state_e state_ff;
  logic [4:0] scan_ff;
  logic [3:0] cand_ff, slot_ff, done_ff;
  logic [4:0] cand_num_ff [MAX_SLOTS];
  logic [3:0] cand_row_ff [MAX_SLOTS];
  slot_s fetch_ff [MAX_SLOTS];
  slot_s [MAX_SLOTS-1:0] disp_ff;
  logic [3:0] disp_cnt_ff;
  logic [7:0] line_ff, disp_line_ff;
  logic [16:0] nxt_addr, attr_addr, pat_addr;
  logic [7:0] row8;
  logic [8:0] height;
  logic visible, mode2, sprites_on, ack_in;
  logic [3:0] limit;
  logic [7:0] term_y;
  logic [MAX_SLOTS-1:0] slot_on;
  pixel_s mix_pix;
  logic mix_coll, coll_event, ovf_event;
  logic [7:0] cur_pat;

  assign mode2 = (scrmode_ff >= SCR_G3);
  assign sprites_on = !ctrl8_ff[CTRL8_HIDE_BIT];
  assign limit = mode2 ? LIMIT_MODE2 : LIMIT_MODE1;
  assign term_y = mode2 ? TERM_Y_MODE2 : TERM_Y_MODE1;
  assign ack_in = VRAM_REQ && VRAM_ACK;

  // ======================================================================
  // apb slave, one wait state so read data comes from a flop
  assign apb_done = PSEL && PENABLE && PREADY;
  assign rd_stat0 = apb_done && !PWRITE && (PADDR == ADDR_STAT0);
  assign rd_stat5 = apb_done && !PWRITE && (PADDR == ADDR_STAT5);

  always_comb
  begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      ADDR_CTRL1: rdata = {30'h0, ctrl1_ff};
      ADDR_PAT_BASE: rdata = {26'h0, patbase_ff};
      ADDR_CTRL8: rdata = {24'h0, ctrl8_ff};
      ADDR_ATTR_BASE: rdata = {22'h0, attrbase_ff};
      ADDR_SCREEN: rdata = {29'h0, scrmode_ff};
      ADDR_STAT0: rdata = {25'h0, ovf_ff, coll_ff, ovfnum_ff};
      ADDR_STAT3: rdata = {24'h0, collx_ff[7:0]};
      ADDR_STAT4: rdata = {31'h0, collx_ff[8]};
      ADDR_STAT5: rdata = {24'h0, colly_ff[7:0]};
      ADDR_STAT6: rdata = {30'h0, colly_ff[9:8]};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY)
      begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata;
        PSLVERR <= !mapped;
      end
      else
        PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ctrl1_ff <= 2'h0;
      patbase_ff <= 6'h00;
      ctrl8_ff <= CTRL8_RESET;
      attrbase_ff <= 10'h000;
      scrmode_ff <= SCR_G1;
    end
    else if (apb_done && PWRITE)
    begin
      case (PADDR)
        ADDR_CTRL1: ctrl1_ff <= PWDATA[1:0];
        ADDR_PAT_BASE: patbase_ff <= PWDATA[5:0];
        ADDR_CTRL8: ctrl8_ff <= PWDATA[7:0];
        ADDR_ATTR_BASE: attrbase_ff <= PWDATA[9:0];
        ADDR_SCREEN: scrmode_ff <= screen_mode_e'(PWDATA[2:0]);
        default: ;
      endcase
    end
  end

  // ======================================================================
  // line fetch: scan attribute y, then load chosen slots
  // height from size and zoom
  assign height = (ctrl1_ff[CTRL1_SIZE_BIT] ? 9'h010 : 9'h008) << ctrl1_ff[CTRL1_ZOOM_BIT];
  assign row8 = line_ff - VRAM_DATA - 8'h01;
  assign visible = ({1'b0, row8} < height);
  assign cur_pat = fetch_ff[slot_ff[2:0]].pat[15:8];

  always_comb
  begin
    logic [4:0] n;
    n = (state_ff == ST_YPOS) ? scan_ff : cand_num_ff[slot_ff[2:0]];
    attr_addr = {attrbase_ff, 7'h00} + {10'h000, n, 2'h0};
  end

  // eight bytes a pattern, 16x16 ignores low two bits
  always_comb
  begin
    logic [7:0] p;
    p = ctrl1_ff[CTRL1_SIZE_BIT] ? {cur_pat[7:2], 2'h0} : cur_pat;
    pat_addr = {patbase_ff, 11'h000} + {6'h00, p, 3'h0}
             + {13'h0000, cand_row_ff[slot_ff[2:0]]};
  end

  always_comb
  begin
    case (state_ff)
      ST_YPOS: nxt_addr = attr_addr;
      ST_XPOS: nxt_addr = attr_addr + 17'h00001;
      ST_PATN: nxt_addr = attr_addr + 17'h00002;
      ST_ACOL: nxt_addr = attr_addr + 17'h00003;
      ST_CTAB: nxt_addr = {attrbase_ff, 7'h00} - COLTAB_OFFSET
                        + {8'h00, cand_num_ff[slot_ff[2:0]], 4'h0}
                        + {13'h0000, cand_row_ff[slot_ff[2:0]]};
      ST_PATL: nxt_addr = pat_addr;
      // left byte has overwritten the pattern number: step from the last address
      ST_PATR: nxt_addr = VRAM_ADDR + 17'h00010;
      default: nxt_addr = 17'h00000;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      VRAM_REQ <= 1'b0;
      VRAM_ADDR <= 17'h00000;
    end
    else if (ack_in)
      VRAM_REQ <= 1'b0;
    else if (state_ff != ST_IDLE && !VRAM_REQ && !LINE_START)
    begin
      VRAM_REQ <= 1'b1;
      VRAM_ADDR <= nxt_addr;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_ff <= ST_IDLE;
      scan_ff <= 5'h00;
      cand_ff <= 4'h0;
      slot_ff <= 4'h0;
      done_ff <= 4'h0;
      line_ff <= 8'h00;
    end
    else if (LINE_START)
    begin
      state_ff <= sprites_on ? ST_YPOS : ST_IDLE;
      line_ff <= LINE_Y;
      scan_ff <= 5'h00;
      cand_ff <= 4'h0;
      slot_ff <= 4'h0;
      done_ff <= 4'h0;
    end
    else if (ack_in)
    begin
      case (state_ff)
        ST_YPOS:
        begin
          if (VRAM_DATA == term_y || (visible && cand_ff == limit)
              || (scan_ff == 5'(NUM_SPRITES - 1)))
            state_ff <= (cand_ff != 4'h0 || (visible && VRAM_DATA != term_y))
                        ? ST_XPOS : ST_IDLE;
          if (visible && VRAM_DATA != term_y && cand_ff != limit)
            cand_ff <= cand_ff + 4'h1;
          scan_ff <= scan_ff + 5'h01;
        end
        ST_XPOS: state_ff <= ST_PATN;
        ST_PATN: state_ff <= mode2 ? ST_CTAB : ST_ACOL;
        ST_ACOL, ST_CTAB: state_ff <= ST_PATL;
        ST_PATL, ST_PATR:
        begin
          if (state_ff == ST_PATL && ctrl1_ff[CTRL1_SIZE_BIT])
            state_ff <= ST_PATR;
          else
          begin
            done_ff <= done_ff + 4'h1;
            slot_ff <= slot_ff + 4'h1;
            state_ff <= (slot_ff + 4'h1 == cand_ff) ? ST_IDLE : ST_XPOS;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign ovf_event = ack_in && state_ff == ST_YPOS && VRAM_DATA != term_y
                   && visible && cand_ff == limit;

  always_ff @(posedge CLOCK)
  begin
    if (ack_in && state_ff == ST_YPOS && visible && cand_ff != limit)
    begin
      cand_num_ff[cand_ff[2:0]] <= scan_ff;
      cand_row_ff[cand_ff[2:0]] <= ctrl1_ff[CTRL1_ZOOM_BIT] ? row8[4:1] : row8[3:0];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (ack_in)
    begin
      case (state_ff)
        ST_XPOS: fetch_ff[slot_ff[2:0]].xpos <= VRAM_DATA;
        ST_PATN: fetch_ff[slot_ff[2:0]].pat <= {VRAM_DATA, 8'h00};
        ST_ACOL, ST_CTAB:
        begin
          fetch_ff[slot_ff[2:0]].color <= VRAM_DATA[3:0];
          fetch_ff[slot_ff[2:0]].early <= VRAM_DATA[COLB_EARLY_BIT];
          fetch_ff[slot_ff[2:0]].merge <= mode2 && VRAM_DATA[COLB_MERGE_BIT];
          fetch_ff[slot_ff[2:0]].ignore <= mode2 && VRAM_DATA[COLB_IGNORE_BIT];
        end
        ST_PATL: fetch_ff[slot_ff[2:0]].pat[15:8] <= VRAM_DATA;
        ST_PATR: fetch_ff[slot_ff[2:0]].pat[7:0] <= VRAM_DATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      disp_cnt_ff <= 4'h0;
      disp_line_ff <= 8'h00;
      disp_ff <= '0;
    end
    else if (LINE_START)
    begin
      disp_cnt_ff <= sprites_on ? done_ff : 4'h0;
      disp_line_ff <= line_ff;
      for (int i = 0; i < MAX_SLOTS; i++)
        disp_ff[i] <= fetch_ff[i];
    end
  end

  // ======================================================================
  // dot rendering
  genvar g;
  generate
    for (g = 0; g < MAX_SLOTS; g++)
    begin : g_slot
      logic [9:0] dx;
      logic [3:0] bi;
      assign dx = {2'h0, PIX_X} + (disp_ff[g].early ? EARLY_SHIFT : 10'h000)
                - {2'h0, disp_ff[g].xpos};
      assign bi = ctrl1_ff[CTRL1_ZOOM_BIT] ? dx[4:1] : dx[3:0];
      assign slot_on[g] = (4'(g) < disp_cnt_ff) && ({1'b0, height} > dx)
                        && disp_ff[g].pat[4'hf - bi]
                        && (!mode2 || disp_ff[g].color != 4'h0);
    end
  endgenerate

  sprite_mixer #(.SLOTS(MAX_SLOTS)) u_mixer (
    .slot_on(slot_on),
    .slots(disp_ff),
    .pix(mix_pix),
    .collide(mix_coll)
  );

  assign coll_event = PIX_EN && sprites_on && mix_coll;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      SPR_VALID <= 1'b0;
      SPR_COLOR <= 4'h0;
    end
    else
    begin
      SPR_VALID <= PIX_EN && sprites_on && mix_pix.valid;
      SPR_COLOR <= mix_pix.color;
    end
  end

  // ======================================================================
  // status: events win over read clears
  // collision flag
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      coll_ff <= 1'b0;
    else if (coll_event)
      coll_ff <= 1'b1;
    else if (rd_stat0)
      coll_ff <= 1'b0;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ovf_ff <= 1'b0;
      ovfnum_ff <= 5'h00;
    end
    else if (ovf_event)
    begin
      ovf_ff <= 1'b1;
      ovfnum_ff <= scan_ff;
    end
    else if (rd_stat0)
      ovf_ff <= 1'b0;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      collx_ff <= 10'h000;
      colly_ff <= 10'h000;
    end
    else if (coll_event && !ctrl8_ff[CTRL8_PTR_BIT] && !ctrl8_ff[CTRL8_PEN_BIT])
    begin
      collx_ff <= {2'h0, PIX_X} + COLL_X_OFFSET;
      colly_ff <= {2'h0, disp_line_ff} + COLL_Y_OFFSET;
    end
    else if (rd_stat5)
    begin
      collx_ff <= 10'h000;
      colly_ff <= 10'h000;
    end
  end

  // ======================================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_coll_loaded;
    coll_event && !ctrl8_ff[CTRL8_PTR_BIT] && !ctrl8_ff[CTRL8_PEN_BIT];
  endsequence

  a_req_hold: assert property (VRAM_REQ && !VRAM_ACK |=> VRAM_REQ && $stable(VRAM_ADDR))
    else $error("video ram request dropped or moved");
  a_coll_flag: assert property (coll_event |=> coll_ff)
    else $error("collision flag not set");
  a_coord_load: assert property (s_coll_loaded |=> collx_ff == $past(PIX_X) + 10'h00c)
    else $error("collision x offset wrong");
  a_coord_keep: assert property (coll_event && !rd_stat5
                                 && (ctrl8_ff[CTRL8_PTR_BIT] || ctrl8_ff[CTRL8_PEN_BIT])
                                 |=> $stable(collx_ff) && $stable(colly_ff))
    else $error("coordinates loaded while pointer flag set");
  a_s5_clear: assert property (rd_stat5 && !coll_event |=> collx_ff == 10'h000 && colly_ff == 10'h000)
    else $error("status 5 read did not clear coordinates");
  a_slot_limit: assert property (cand_ff <= (mode2 ? 4'h8 : 4'h4))
    else $error("too many sprites taken for one line");
  a_hide_blank: assert property (ctrl8_ff[CTRL8_HIDE_BIT] [*2] |-> !SPR_VALID)
    else $error("sprite shown while display disabled");
  a_term_stop: assert property (ack_in && state_ff == ST_YPOS && VRAM_DATA == term_y
                                && !LINE_START
                                |=> state_ff == (($past(cand_ff) == 4'h0) ? ST_IDLE : ST_XPOS))
    else $error("terminator y did not end the scan");
  a_ovf_flag: assert property (ovf_event |=> ovf_ff && ovfnum_ff == $past(scan_ff))
    else $error("overflow flag or number wrong");

endmodule

// [hw/sprite_mixer.sv]
// per-pixel priority, colour merge and collision across the line slots
`timescale 1ns/1ps
module sprite_mixer
  import sprite_pkg::*;
#(
  parameter int SLOTS = MAX_SLOTS
)
(
  // slot state for the current dot
  input wire logic [SLOTS-1:0] slot_on,
  input wire slot_s [SLOTS-1:0] slots,
  // merged result
  output pixel_s pix,
  output logic collide
);

  // ======================================================================
  // walk slots from highest precedence down
  always_comb
  begin
    logic any;
    logic solid;
    any = 1'b0;
    solid = 1'b0;
    pix = '0;
    collide = 1'b0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (slot_on[i])
      begin
        if (!slots[i].merge)
        begin
          if (!any)
            pix.color = slots[i].color;
          any = 1'b1;
          if (!slots[i].ignore)
          begin
            if (solid)
              collide = 1'b1;
            solid = 1'b1;
          end
        end
        else if (any)
          pix.color = pix.color | slots[i].color;
      end
    end
    pix.valid = any;
  end

endmodule

// [hw/sprite_pkg.sv]
// constants, types and register map shared by the sprite engine files
package sprite_pkg;

  // ======================================================================
  // sprite table geometry
  localparam int NUM_SPRITES = 32;
  localparam int MAX_SLOTS = 8;
  localparam logic [3:0] LIMIT_MODE1 = 4'h4;
  localparam logic [3:0] LIMIT_MODE2 = 4'h8;
  localparam logic [7:0] TERM_Y_MODE1 = 8'hd0;
  localparam logic [7:0] TERM_Y_MODE2 = 8'hd8;
  localparam logic [16:0] COLTAB_OFFSET = 17'h00200;
  localparam logic [9:0] EARLY_SHIFT = 10'h020;
  localparam logic [9:0] COLL_X_OFFSET = 10'h00c;
  localparam logic [9:0] COLL_Y_OFFSET = 10'h008;

  // ======================================================================
  // register byte addresses on the apb slave
  localparam logic [11:0] ADDR_CTRL1 = 12'h000;
  localparam logic [11:0] ADDR_PAT_BASE = 12'h004;
  localparam logic [11:0] ADDR_CTRL8 = 12'h008;
  localparam logic [11:0] ADDR_ATTR_BASE = 12'h00c;
  localparam logic [11:0] ADDR_SCREEN = 12'h010;
  localparam logic [11:0] ADDR_STAT0 = 12'h020;
  localparam logic [11:0] ADDR_STAT3 = 12'h02c;
  localparam logic [11:0] ADDR_STAT4 = 12'h030;
  localparam logic [11:0] ADDR_STAT5 = 12'h034;
  localparam logic [11:0] ADDR_STAT6 = 12'h038;

  // ======================================================================
  // field positions and reset values
  localparam int CTRL1_ZOOM_BIT = 0;
  localparam int CTRL1_SIZE_BIT = 1;
  localparam int CTRL8_HIDE_BIT = 1;
  localparam int CTRL8_PEN_BIT = 6;
  localparam int CTRL8_PTR_BIT = 7;
  localparam int STAT0_COLL_BIT = 5;
  localparam int STAT0_OVF_BIT = 6;
  localparam int COLB_EARLY_BIT = 7;
  localparam int COLB_MERGE_BIT = 6;
  localparam int COLB_IGNORE_BIT = 5;
  localparam logic [7:0] CTRL8_RESET = 8'h00;

  // ======================================================================
  // screen modes and fetch states
  typedef enum logic [2:0] {
    SCR_G1 = 3'h0, SCR_G2 = 3'h1, SCR_MC = 3'h2, SCR_G3 = 3'h3,
    SCR_G4 = 3'h4, SCR_G5 = 3'h5, SCR_G6 = 3'h6, SCR_G7 = 3'h7
  } screen_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_YPOS = 3'h1, ST_XPOS = 3'h2, ST_PATN = 3'h3,
    ST_ACOL = 3'h4, ST_CTAB = 3'h5, ST_PATL = 3'h6, ST_PATR = 3'h7
  } fetch_state_e;

  typedef struct packed {
    logic [7:0] xpos;
    logic [15:0] pat;
    logic [3:0] color;
    logic early;
    logic merge;
    logic ignore;
  } slot_s;

  typedef struct packed {
    logic valid;
    logic [3:0] color;
  } pixel_s;

endpackage

// [tb/testbench.sv]
// self-checking bench for the sprite engine
`timescale 1ns/1ps
module testbench;
  import sprite_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr;
  logic vram_req, vram_ack, line_start, pix_en, spr_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [16:0] vram_addr;
  logic [7:0] vram_data, line_y, pix_x, term_y;
  logic [3:0] spr_color, vdelay;
  int bad_count, check_count;

  sprite_engine DUT (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .VRAM_REQ(vram_req), .VRAM_ADDR(vram_addr), .VRAM_ACK(vram_ack),
    .VRAM_DATA(vram_data), .LINE_START(line_start), .LINE_Y(line_y), .PIX_EN(pix_en),
    .PIX_X(pix_x), .SPR_VALID(spr_valid), .SPR_COLOR(spr_color));

  vram_model vram (.clk(clock), .rst(rst), .req(vram_req), .addr(vram_addr),
    .delay(vdelay), .ack(vram_ack), .data(vram_data));

  // ======================================================================
  // common tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // no assumed wait count; only the watchdog ends a hang
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask

  // one dot in, compare {valid, colour} one cycle later; colour ignored if blank
  task pix(input logic [7:0] x, input logic [4:0] exp);
    @(posedge clock);
    pix_en <= 1'b1;
    pix_x <= x;
    @(posedge clock);
    pix_en <= 1'b0;
    @(posedge clock);
    chk("sprite dot", {27'h0, spr_valid, (spr_valid ? spr_color : 4'h0)},
        {27'h0, exp[4], (exp[4] ? exp[3:0] : 4'h0)});
  endtask

  // no done flag on the fetch: wait until the read port goes quiet
  task line(input logic [7:0] y);
    int n, idle;
    @(posedge clock);
    line_start <= 1'b1;
    line_y <= y;
    @(posedge clock);
    line_start <= 1'b0;
    idle = 0;
    for (n = 0; n < 3000 && idle < 40; n++)
    begin
      @(posedge clock);
      idle = (vram_req === 1'b0) ? idle + 1 : 0;
    end
  endtask

  task show;
    line(8'd10);
    line(8'd11);
  endtask

  // attribute at 1024, colour table at 512; only the displayed row 0 carries colour
  task spr(input int n, input logic [7:0] y, x, p, c);
    int r;
    vram.mem[1024 + 4 * n] = y;
    vram.mem[1025 + 4 * n] = x;
    vram.mem[1026 + 4 * n] = p;
    vram.mem[1027 + 4 * n] = c;
    for (r = 0; r < 16; r++)
      vram.mem[512 + 16 * n + r] = (r == 0) ? c : 8'h00;
  endtask

  task setup(input logic [2:0] scr);
    wr(ADDR_SCREEN, {29'h0, scr});
    wr(ADDR_ATTR_BASE, 32'h8);
    wr(ADDR_PAT_BASE, 32'h1);
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_CTRL8, 32'h0);
    term_y = (scr >= 3'h3) ? TERM_Y_MODE2 : TERM_Y_MODE1;
  endtask

  // ======================================================================
  // scenarios
  task t_regs;
    logic [31:0] r;
    logic e;
    rd(ADDR_CTRL8, 32'h0, "ctrl8 reset");
    rd(ADDR_STAT0, 32'h0, "stat0 reset");
    wr(ADDR_CTRL1, 32'h3);
    rd(ADDR_CTRL1, 32'h3, "ctrl1 readback");
    apb(1'b0, 12'h0fc, 32'h0, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    $display("test regs done");
  endtask

  task t_mode1;
    setup(3'h0);
    spr(0, 8'd9, 8'd20, 8'd0, 8'h05);
    spr(1, 8'd9, 8'd22, 8'd4, 8'h07);
    spr(2, 8'd9, 8'd40, 8'd0, 8'h83);
    spr(3, term_y, 8'h0, 8'h0, 8'h0);
    show;
    pix(8'd19, 5'h00);
    pix(8'd20, 5'h15);
    pix(8'd26, 5'h15);
    pix(8'd28, 5'h17);
    pix(8'd30, 5'h00);
    pix(8'd10, 5'h13);
    pix(8'd45, 5'h00);
    rd(ADDR_STAT0, 32'h20, "collision flag");
    rd(ADDR_STAT0, 32'h00, "flag cleared by read");
    $display("test mode1 done");
  endtask

  task t_limit(input logic [2:0] scr, input int lim);
    int n;
    setup(scr);
    for (n = 0; n <= lim; n++)
      spr(n, 8'd9, 8'(16 * n), 8'd0, 8'(n + 1));
    spr(lim + 1, term_y, 8'h0, 8'h0, 8'h0);
    show;
    pix(8'(16 * lim - 14), {1'b1, 4'(lim)});
    pix(8'(16 * lim + 2), 5'h00);
    rd(ADDR_STAT0, 32'h40 | 32'(lim), "overflow status");
    $display("test line limit %0d done", lim);
  endtask

  task t_merge;
    setup(3'h3);
    spr(0, 8'd9, 8'd20, 8'd0, 8'h01);
    spr(1, 8'd9, 8'd24, 8'd0, 8'h42);
    spr(2, 8'd9, 8'd60, 8'd0, 8'h04);
    spr(3, 8'd9, 8'd64, 8'd0, 8'h05);
    spr(4, term_y, 8'h0, 8'h0, 8'h0);
    show;
    pix(8'd26, 5'h13);
    pix(8'd30, 5'h00);
    rd(ADDR_STAT0, 32'h08, "no merge collision");
    pix(8'd66, 5'h14);
    rd(ADDR_STAT3, 32'h4e, "collision x low");
    rd(ADDR_STAT4, 32'h00, "collision x high");
    rd(ADDR_STAT5, 32'h12, "collision y low");
    rd(ADDR_STAT6, 32'h00, "collision y high");
    rd(ADDR_STAT3, 32'h00, "coords cleared");
    rd(ADDR_STAT0, 32'h28, "collision flag");
    wr(ADDR_CTRL8, 32'h40);
    pix(8'd66, 5'h14);
    rd(ADDR_STAT3, 32'h00, "coords held off");
    rd(ADDR_STAT0, 32'h28, "flag still set");
    wr(ADDR_CTRL8, 32'h02);
    pix(8'd66, 5'h00);
    $display("test merge done");
  endtask

  task t_size;
    setup(3'h0);
    spr(0, 8'd9, 8'd100, 8'd6, 8'h09);
    spr(1, term_y, 8'h0, 8'h0, 8'h0);
    wr(ADDR_CTRL1, 32'h2);
    show;
    pix(8'd102, 5'h00);
    pix(8'd113, 5'h19);
    pix(8'd116, 5'h00);
    wr(ADDR_CTRL1, 32'h3);
    show;
    pix(8'd106, 5'h00);
    pix(8'd130, 5'h19);
    pix(8'd132, 5'h00);
    $display("test size done");
  endtask

  task t_term(input logic [2:0] scr);
    setup(scr);
    spr(0, 8'd9, 8'd0, 8'd0, 8'h01);
    spr(1, term_y, 8'd60, 8'd0, 8'h02);
    spr(2, 8'd9, 8'd40, 8'd0, 8'h03);
    show;
    pix(8'd2, 5'h11);
    pix(8'd42, 5'h00);
    $display("test terminator done");
  endtask

  // ======================================================================
  // clock, main sequence and watchdog
  initial
  begin
    clock = 1'b0;
    forever
      #25 clock = ~clock;
  end

  initial
  begin
    int i;
    {psel, penable, pwrite, line_start, pix_en} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    line_y = 8'h00;
    pix_x = 8'h00;
    vdelay = 4'h0;
    term_y = 8'h00;
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 64; i++)
      vram.mem[2048 + i] = (i / 8 == 4) ? 8'h0f : 8'hff;
    t_regs;
    t_mode1;
    vdelay <= 4'h3;
    t_limit(3'h0, 4);
    t_limit(3'h3, 8);
    t_merge;
    vdelay <= 4'h0;
    t_size;
    t_term(3'h0);
    t_term(3'h3);
    report_and_stop;
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    report_and_stop;
  end
endmodule

// [tb/vram_model.sv]
// video ram model that answers engine reads after a programmable wait
`timescale 1ns/1ps
module vram_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // read port
  input wire logic req,
  input wire logic [16:0] addr,
  input wire logic [3:0] delay,
  output logic ack,
  output logic [7:0] data
);
  // ======================================================================
  // storage, filled by the bench between lines
  logic [7:0] mem [0:131071];
  logic [7:0] last_ff;
  logic [3:0] wait_ff;

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
  end

  // ======================================================================
  // answer; data lines toggle away from the last byte when not acking
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
      data <= 8'h00;
      last_ff <= 8'h00;
      wait_ff <= 4'h0;
    end
    else if (req && !ack && wait_ff >= delay)
    begin
      ack <= 1'b1;
      data <= mem[addr];
      last_ff <= mem[addr];
      wait_ff <= 4'h0;
    end
    else
    begin
      ack <= 1'b0;
      data <= ~last_ff;
      wait_ff <= (req && !ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule
